//--- include/sqecc_pkg.sv
// Shared constants and types for the separate-I/O ECC SRAM port and its controller
package sqecc_pkg;

  // ----------------------------------------------------------------
  // Data path geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 18;                 // Data bits per beat
  localparam int LANE_W = 9;                  // Bits per byte-write lane
  localparam int LANES = 2;                   // Lanes per beat
  localparam int CHK_W = 5;                   // Hidden check bits per lane word
  localparam int LWORD_W = 2 * LANE_W;        // Two-beat lane word
  localparam int CW_W = LWORD_W + CHK_W;      // Stored lane word with check bits
  localparam int WORD_W = LANES * CW_W;       // Stored word per address
  localparam int ADDR_W = 10;                 // Address inputs
  localparam int DEPTH = 1 << ADDR_W;         // Words in the array

  // ----------------------------------------------------------------
  // Power-up timing, in link clock cycles
  // ----------------------------------------------------------------
  localparam int ZQ_SETTLE_CYC = 163840;
  localparam int DLL_LOCK_CYC = 65536;
  localparam int CNT_W = 18;

  // ----------------------------------------------------------------
  // Controller link clock phases (four system clocks per link clock)
  // ----------------------------------------------------------------
  localparam logic [1:0] PH_CMD = 2'h0;       // Command and first beat set up
  localparam logic [1:0] PH_KRISE = 2'h1;     // True clock rises entering this
  localparam logic [1:0] PH_BEAT2 = 2'h2;     // Write address and second beat set up
  localparam logic [1:0] PH_KBRISE = 2'h3;    // Complementary clock rises entering this

  // Controller power-up states
  typedef enum logic [1:0] {
    SQECC_ST_ZQ = 2'h0,
    SQECC_ST_DLL = 2'h1,
    SQECC_ST_RUN = 2'h3
  } sqecc_init_e;

endpackage

//--- include/sqecc_link_if.sv
// Link between the SRAM port and its external controller
`timescale 1ns/1ns
`default_nettype none
interface sqecc_link_if;
  import sqecc_pkg::*;

  logic k;                          // True input clock
  logic kb;                         // Complementary input clock
  logic rd_n;                       // Read request, active low
  logic wr_n;                       // Write request, active low
  logic [ADDR_W-1:0] addr_in;       // Shared address inputs
  logic [DATA_W-1:0] wr_data;       // Write data beats
  logic [LANES-1:0] lane_wr_en_n;   // Lane write enables, active low
  logic term_enable;                // Output idle drive select
  logic dll_off_n;                  // Loop disable, active low
  logic [DATA_W-1:0] rd_data;       // Read data beats
  logic rd_oe;                      // Read data drivers on
  logic rd_data_valid;              // Read data beat valid
  logic echo_clk;                   // Echo of the true clock

  modport dev (
    input k, kb, rd_n, wr_n, addr_in, wr_data, lane_wr_en_n, term_enable, dll_off_n,
    output rd_data, rd_oe, rd_data_valid, echo_clk
  );

  modport ctl (
    output k, kb, rd_n, wr_n, addr_in, wr_data, lane_wr_en_n, term_enable, dll_off_n,
    input rd_data, rd_oe, rd_data_valid, echo_clk
  );

endinterface
`default_nettype wire

//--- rtl/sqecc_dev.sv
// SRAM port end: read and write pipelines, lane masking and error correction
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// RL1 - True clock rise captures address and read request
// RL2 - Low read starts read, high deselects
// RL3 - Beats leave on complementary then true rise
// RL4 - Write request on true, address on complementary
// RL5 - Low write starts write, high stores nothing
// RL6 - First write beat taken with write request
// RL7 - Second beat taken with write address
// RL8 - Controller waits 163,840 cycles for impedance
// RL9 - Then 65,536 cycles for loop lock
// RL10 - Low loop-disable input turns loop off
// RL11 - Hamming code, five check bits per lane
// RL12 - Single errors only; multiple errors pass silently
// RL13 - Lane enables sampled with their data beats
// RL14 - High lane enable keeps old lane content
// RL15 - Each write stores two beats per address
// RL16 - Any lane mask allowed on either beat
// RL17 - Half write turns correction off until reset
// RL18 - Idle cycle outputs float or drive low
// RL19 - Single-beat enables write only that beat
// RL20 - Check bits stored, single errors corrected
module sqecc_dev
  import sqecc_pkg::*;
(
  input wire logic rst_n_i,
  sqecc_link_if.dev link,
  output logic dll_on_o,
  output logic ecc_on_o
);

  // ----------------------------------------------------------------
  // Hamming helpers
  // ----------------------------------------------------------------
  // Places data at non-power-of-two positions, check bits at powers of two
  function automatic logic [CW_W:0] place(input logic [LWORD_W-1:0] d,
                                          input logic [CHK_W-1:0] c);
    logic [CW_W:0] cw;
    int k;
    cw = '0;
    k = 0;
    for (int p = 1; p <= CW_W; p++) begin
      if ((p & (p - 1)) == 0) begin
        cw[p] = c[$clog2(p)];
      end else begin
        cw[p] = d[k];
        k++;
      end
    end
    return cw;
  endfunction

  // Parity over each position group; check bits when the check slots are zero
  function automatic logic [CHK_W-1:0] syndrome(input logic [CW_W:0] cw);
    logic [CHK_W-1:0] s;
    s = '0;
    for (int p = 1; p <= CW_W; p++) begin
      for (int i = 0; i < CHK_W; i++) begin
        if (p[i]) begin
          s[i] = s[i] ^ cw[p];
        end
      end
    end
    return s;
  endfunction

  // Pulls the data bits back out of a codeword
  function automatic logic [LWORD_W-1:0] extract(input logic [CW_W:0] cw);
    logic [LWORD_W-1:0] d;
    int k;
    d = '0;
    k = 0;
    for (int p = 1; p <= CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = cw[p];
        k++;
      end
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] mem [DEPTH];
  logic rd_s1_r;
  logic rd_s2_r;
  logic [ADDR_W-1:0] rd_addr1_r;
  logic [ADDR_W-1:0] rd_addr2_r;
  logic wr_cmd_r;
  logic [DATA_W-1:0] wr_d1_r;
  logic [LANES-1:0] wr_en1_n_r;
  logic ecc_off_r;
  logic [DATA_W-1:0] beat2_r;
  logic [DATA_W-1:0] kq_r;
  logic kv_r;
  logic koe_r;
  logic [DATA_W-1:0] kbq_r;
  logic kbv_r;
  logic kboe_r;
  logic own_k_r;
  logic own_kb_r;
  logic dll_on_r;
  logic [WORD_W-1:0] wr_word;
  logic wr_half;
  logic [DATA_W-1:0] rd_beat1;
  logic [DATA_W-1:0] rd_beat2;

  // ----------------------------------------------------------------
  // True clock side: command capture and second read beat
  // ----------------------------------------------------------------
  // Read command pipeline, two stages deep
  always_ff @(posedge link.k or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_s1_r <= 1'b0;
      rd_s2_r <= 1'b0;
      rd_addr1_r <= '0;
      rd_addr2_r <= '0;
    end else begin
      rd_s1_r <= ~link.rd_n; // RL1 RL2
      rd_addr1_r <= link.addr_in; // RL1
      rd_s2_r <= rd_s1_r;
      rd_addr2_r <= rd_addr1_r;
    end
  end

  // Write request with first beat and its lane enables
  always_ff @(posedge link.k or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_cmd_r <= 1'b0;
      wr_d1_r <= '0;
      wr_en1_n_r <= '1;
    end else begin
      wr_cmd_r <= ~link.wr_n; // RL4 RL5
      wr_d1_r <= link.wr_data; // RL6
      wr_en1_n_r <= link.lane_wr_en_n; // RL13
    end
  end

  // Second beat of a read, or the idle drive two cycles after a non-read
  always_ff @(posedge link.k or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kq_r <= '0;
      kv_r <= 1'b0;
      koe_r <= 1'b0;
    end else if (rd_s2_r) begin
      kq_r <= beat2_r; // RL3
      kv_r <= 1'b1;
      koe_r <= 1'b1;
    end else begin
      kq_r <= '0; // RL18
      kv_r <= 1'b0;
      koe_r <= link.term_enable; // RL18
    end
  end

  // Output ownership, loop enable follow
  always_ff @(posedge link.k or negedge rst_n_i) begin
    if (!rst_n_i) begin
      own_k_r <= 1'b0;
      dll_on_r <= 1'b0;
    end else begin
      own_k_r <= own_kb_r;
      dll_on_r <= link.dll_off_n; // RL10
    end
  end

  // ----------------------------------------------------------------
  // Array access: merge, encode and correct
  // ----------------------------------------------------------------
  // Merged write word per lane; masked beats keep the stored bits
  always_comb begin
    logic [CW_W-1:0] old_w;
    logic [LANE_W-1:0] b1;
    logic [LANE_W-1:0] b2;
    old_w = '0;
    b1 = '0;
    b2 = '0;
    wr_word = mem[link.addr_in];
    wr_half = 1'b0;
    for (int l = 0; l < LANES; l++) begin
      old_w = mem[link.addr_in][l*CW_W +: CW_W];
      b1 = wr_en1_n_r[l] ? old_w[LANE_W-1:0] : wr_d1_r[l*LANE_W +: LANE_W]; // RL13 RL14 RL19
      b2 = link.lane_wr_en_n[l] ? old_w[LWORD_W-1:LANE_W] : link.wr_data[l*LANE_W +: LANE_W];
      if (!(wr_en1_n_r[l] && link.lane_wr_en_n[l])) begin
        wr_word[l*CW_W +: CW_W] = {syndrome(place({b2, b1}, '0)), b2, b1}; // RL11 RL20
      end
      wr_half = wr_half | (wr_en1_n_r[l] ^ link.lane_wr_en_n[l]); // RL17
    end
  end

  // Read word per lane, corrected while correction is on
  always_comb begin
    logic [CW_W:0] cw;
    logic [CHK_W-1:0] s;
    logic [LWORD_W-1:0] d;
    cw = '0;
    s = '0;
    d = '0;
    rd_beat1 = '0;
    rd_beat2 = '0;
    for (int l = 0; l < LANES; l++) begin
      cw = place(mem[rd_addr2_r][l*CW_W +: LWORD_W], mem[rd_addr2_r][l*CW_W+LWORD_W +: CHK_W]);
      s = syndrome(cw);
      if (!ecc_off_r && s != '0 && int'(s) <= CW_W) begin
        cw[s] = ~cw[s]; // RL20 RL12
      end
      d = extract(cw);
      rd_beat1[l*LANE_W +: LANE_W] = d[LANE_W-1:0];
      rd_beat2[l*LANE_W +: LANE_W] = d[LWORD_W-1:LANE_W];
    end
  end

  // ----------------------------------------------------------------
  // Complementary clock side: write commit and first read beat
  // ----------------------------------------------------------------
  // Commit a two-beat write at the captured address
  always_ff @(posedge link.kb) begin
    if (wr_cmd_r) begin
      mem[link.addr_in] <= wr_word; // RL4 RL7 RL15 RL16
    end
  end

  // Sticky correction shutdown, cleared only by reset
  always_ff @(posedge link.kb or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ecc_off_r <= 1'b0;
    end else if (wr_cmd_r && wr_half) begin
      ecc_off_r <= 1'b1; // RL17
    end
  end

  // First read beat; otherwise carry the true-clock value forward
  always_ff @(posedge link.kb or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kbq_r <= '0;
      kbv_r <= 1'b0;
      kboe_r <= 1'b0;
      beat2_r <= '0;
    end else if (rd_s2_r) begin
      kbq_r <= rd_beat1; // RL3
      kbv_r <= 1'b1;
      kboe_r <= 1'b1;
      beat2_r <= rd_beat2;
    end else begin
      kbq_r <= kq_r;
      kbv_r <= 1'b0;
      kboe_r <= koe_r;
    end
  end

  // Output ownership toggles on every complementary rise
  always_ff @(posedge link.kb or negedge rst_n_i) begin
    if (!rst_n_i) begin
      own_kb_r <= 1'b1; // Echo low until the first true rise
    end else begin
      own_kb_r <= ~own_k_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs: the side that clocked last owns the pins
  // ----------------------------------------------------------------
  assign link.rd_data = (own_k_r ^ own_kb_r) ? kbq_r : kq_r;
  assign link.rd_data_valid = (own_k_r ^ own_kb_r) ? kbv_r : kv_r;
  assign link.rd_oe = (own_k_r ^ own_kb_r) ? kboe_r : koe_r;
  assign link.echo_clk = ~(own_k_r ^ own_kb_r); // High after true rise
  assign dll_on_o = dll_on_r;
  assign ecc_on_o = ~ecc_off_r;

endmodule
`default_nettype wire

//--- rtl/sqecc_ctl.sv
// Controller end: link clock divider, power-up wait, command launch, read capture
`timescale 1ns/1ns
`default_nettype none
module sqecc_ctl
  import sqecc_pkg::*;
#(
  parameter int ZQ_CYC = ZQ_SETTLE_CYC,
  parameter int DLL_CYC = DLL_LOCK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  sqecc_link_if.ctl link,
  input wire logic term_en_i,
  input wire logic rd_req_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  input wire logic wr_req_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [2*DATA_W-1:0] wr_data_i,
  input wire logic [2*LANES-1:0] wr_lane_en_n_i,
  output logic slot_o,
  output logic init_done_o,
  output logic [2*DATA_W-1:0] rd_data_o,
  output logic rd_valid_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0] ph_r;
  logic [1:0] ph_nxt;
  sqecc_init_e st_r;
  logic [CNT_W-1:0] cnt_r;
  logic k_r;
  logic kb_r;
  logic rd_n_r;
  logic wr_n_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wd_r;
  logic [LANES-1:0] en_n_r;
  logic [ADDR_W-1:0] wa_q_r;
  logic [DATA_W-1:0] d2_q_r;
  logic [LANES-1:0] en2_q_r;
  logic slot_r;
  logic term_r;
  logic [DATA_W-1:0] rdd_s1_r;
  logic [DATA_W-1:0] rdd_s2_r;
  logic rdv_s1_r;
  logic rdv_s2_r;
  logic [DATA_W-1:0] lo_r;
  logic got_r;
  logic [2*DATA_W-1:0] rdo_r;
  logic rdov_r;
  logic take;

  assign ph_nxt = ph_r + 2'h1;
  assign take = slot_r && (ph_r == PH_KBRISE);

  // ----------------------------------------------------------------
  // Link clock divider, true clock and its exact complement
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_r <= PH_CMD;
      k_r <= 1'b0;
      kb_r <= 1'b1;
    end else begin
      ph_r <= ph_nxt;
      k_r <= (ph_nxt == PH_KRISE) || (ph_nxt == PH_BEAT2);
      kb_r <= (ph_nxt == PH_KBRISE) || (ph_nxt == PH_CMD);
    end
  end

  // ----------------------------------------------------------------
  // Power-up wait: impedance settle, then loop lock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= SQECC_ST_ZQ;
      cnt_r <= '0;
    end else if (ph_r == PH_KBRISE) begin
      case (st_r)
        SQECC_ST_ZQ: begin
          if (cnt_r == CNT_W'(ZQ_CYC - 1)) begin
            st_r <= SQECC_ST_DLL; // RL8
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        SQECC_ST_DLL: begin
          if (cnt_r == CNT_W'(DLL_CYC - 1)) begin
            st_r <= SQECC_ST_RUN; // RL9
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        SQECC_ST_RUN: begin
          cnt_r <= '0;
        end
        default: begin
          st_r <= SQECC_ST_ZQ;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // Request slot, one per link cycle once running
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_r <= 1'b0;
      term_r <= 1'b0;
    end else begin
      slot_r <= (ph_nxt == PH_KBRISE) && (st_r == SQECC_ST_RUN); // RL9
      term_r <= term_en_i;
    end
  end

  // ----------------------------------------------------------------
  // Command and data launch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      addr_r <= '0;
      wd_r <= '0;
      en_n_r <= '1;
      wa_q_r <= '0;
      d2_q_r <= '0;
      en2_q_r <= '1;
    end else if (ph_nxt == PH_CMD) begin
      rd_n_r <= ~(take && rd_req_i); // RL2
      wr_n_r <= ~(take && wr_req_i); // RL5
      addr_r <= rd_addr_i;
      wd_r <= wr_data_i[DATA_W-1:0]; // RL6
      en_n_r <= wr_lane_en_n_i[LANES-1:0]; // RL16
      wa_q_r <= wr_addr_i;
      d2_q_r <= wr_data_i[2*DATA_W-1:DATA_W];
      en2_q_r <= wr_lane_en_n_i[2*LANES-1:LANES];
    end else if (ph_nxt == PH_BEAT2) begin
      addr_r <= wa_q_r;
      wd_r <= d2_q_r; // RL7
      en_n_r <= en2_q_r; // RL16
    end
  end

  // ----------------------------------------------------------------
  // Read return: two-flop capture, then pair beats by phase
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdd_s1_r <= '0;
      rdd_s2_r <= '0;
      rdv_s1_r <= 1'b0;
      rdv_s2_r <= 1'b0;
    end else begin
      rdd_s1_r <= link.rd_data;
      rdd_s2_r <= rdd_s1_r;
      rdv_s1_r <= link.rd_data_valid;
      rdv_s2_r <= rdv_s1_r;
    end
  end

  // Beat one settles in phase two, beat two in phase zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_r <= '0;
      got_r <= 1'b0;
      rdo_r <= '0;
      rdov_r <= 1'b0;
    end else begin
      rdov_r <= 1'b0;
      if (ph_r == PH_BEAT2) begin
        lo_r <= rdd_s2_r;
        got_r <= rdv_s2_r;
      end else if (ph_r == PH_CMD) begin
        got_r <= 1'b0;
        if (got_r && rdv_s2_r) begin
          rdo_r <= {rdd_s2_r, lo_r}; // RL3
          rdov_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.k = k_r;
  assign link.kb = kb_r;
  assign link.rd_n = rd_n_r;
  assign link.wr_n = wr_n_r;
  assign link.addr_in = addr_r;
  assign link.wr_data = wd_r;
  assign link.lane_wr_en_n = en_n_r;
  assign link.term_enable = term_r;
  assign link.dll_off_n = 1'b1; // Loop kept enabled
  assign slot_o = slot_r;
  assign init_done_o = (st_r == SQECC_ST_RUN);
  assign rd_data_o = rdo_r;
  assign rd_valid_o = rdov_r;

endmodule
`default_nettype wire

//--- test/sqecc_props.sv
// Concurrent checks on the link between the SRAM port and its controller
`timescale 1ns/1ns
`default_nettype none
module sqecc_props
  import sqecc_pkg::*;
(
  input wire logic rst_n_i,
  input wire logic k,
  input wire logic kb,
  input wire logic rd_n,
  input wire logic term_enable,
  input wire logic dll_off_n,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_oe,
  input wire logic rd_data_valid,
  input wire logic echo_clk
);
  // ----------------------------------------
  // Read return and idle drive
  // ----------------------------------------
  chk_beat_one: assert property (
    @(posedge k) disable iff (!rst_n_i) !rd_n |-> ##2 (rd_data_valid && rd_oe))
    else $error("first read beat missing");
  chk_beat_two: assert property (
    @(posedge kb) disable iff (!rst_n_i) !rd_n |-> ##2 (rd_data_valid && rd_oe))
    else $error("second read beat missing");
  chk_deselect_quiet: assert property (
    @(posedge k) disable iff (!rst_n_i) rd_n |-> ##2 !rd_data_valid)
    else $error("data returned for deselect");
  chk_idle_drive: assert property (
    @(posedge kb) disable iff (!rst_n_i)
    rd_n && $stable(term_enable) ##2 $stable(term_enable)
    |-> (rd_data == '0 && rd_oe == term_enable && !rd_data_valid))
    else $error("idle output drive wrong");
  chk_valid_driven: assert property (
    @(posedge kb) disable iff (!rst_n_i) rd_data_valid |-> rd_oe)
    else $error("valid beat not driven");
  // ----------------------------------------
  // Clock relations and loop control
  // ----------------------------------------
  chk_echo_high: assert property (
    @(posedge kb) disable iff (!rst_n_i) echo_clk)
    else $error("echo clock low before kb rise");
  chk_echo_low: assert property (
    @(posedge k) disable iff (!rst_n_i) !echo_clk)
    else $error("echo clock high before k rise");
  chk_clk_pair: assert property (
    @(posedge kb) disable iff (!rst_n_i) k ##1 k)
    else $error("kb not complement of k");
  chk_loop_on: assert property (
    @(posedge k) disable iff (!rst_n_i) dll_off_n)
    else $error("loop disabled");
endmodule
`default_nettype wire

//--- test/sqecc_tb_top.sv
// Testbench joining the SRAM port and its controller
`timescale 1ns/1ns
`default_nettype none
module sqecc_tb_top;
  import sqecc_pkg::*;
  localparam int TZQ = 8;
  localparam int TDLL = 4;
  localparam logic [15:0] MASKS = 16'h0fa5;
  logic clk_i, rst_n_i, term_en_i, rd_req_i, wr_req_i;
  logic slot_o, init_done_o, rd_valid_o, dll_on_o, ecc_on_o, ecc_exp;
  logic [ADDR_W-1:0] rd_addr_i, wr_addr_i;
  logic [2*DATA_W-1:0] wr_data_i, rd_data_o;
  logic [2*LANES-1:0] wr_lane_en_n_i;
  logic [2*DATA_W-1:0] mem [DEPTH];
  logic [2*DATA_W-1:0] exp_q [$];
  int mismatches, check_count, cyc;

  sqecc_link_if link();
  sqecc_ctl #(.ZQ_CYC(TZQ), .DLL_CYC(TDLL)) i_sqecc_ctl (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .link(link), .term_en_i(term_en_i), .rd_req_i(rd_req_i),
    .rd_addr_i(rd_addr_i), .wr_req_i(wr_req_i), .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i), .wr_lane_en_n_i(wr_lane_en_n_i), .slot_o(slot_o),
    .init_done_o(init_done_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
  sqecc_dev i_sqecc_dev (.rst_n_i(rst_n_i), .link(link), .dll_on_o(dll_on_o),
    .ecc_on_o(ecc_on_o));
  sqecc_props i_sqecc_props (.rst_n_i(rst_n_i), .k(link.k), .kb(link.kb),
    .rd_n(link.rd_n), .term_enable(link.term_enable), .dll_off_n(link.dll_off_n),
    .rd_data(link.rd_data), .rd_oe(link.rd_oe), .rd_data_valid(link.rd_data_valid),
    .echo_clk(link.echo_clk));

  // System clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Compare, verdict and read monitor
  // ----------------------------------------
  task automatic check(input logic [2*DATA_W-1:0] seen, input logic [2*DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Returned words checked in issue order
  always @(negedge clk_i) begin
    if (rst_n_i && rd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(36'h1, 36'h0);
      end else begin
        check(rd_data_o, exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    check(ecc_on_o, 1'b1);
    rst_n_i = 1'b1;
    cyc = 0;
    while (init_done_o !== 1'b1 && cyc < 400) begin
      check(slot_o, 1'b0);
      @(posedge clk_i);
      #1;
      cyc++;
    end
    if (cyc >= 400) begin
      mismatches++;
      finish_test();
    end else begin
      check(cyc >= (TZQ + TDLL) * 4, 1'b1);
      check(dll_on_o, 1'b1);
      ecc_exp = 1'b1;
    end
  endtask

  // One slot: optional read, optional write; a read sees its own slot's write
  task automatic op(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
      input logic [ADDR_W-1:0] wa, input logic [2*DATA_W-1:0] wd, input logic [3:0] wen);
    int n;
    logic [2*DATA_W-1:0] m;
    n = 0;
    while (slot_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 20) begin
      mismatches++;
      finish_test();
    end else begin
      {rd_req_i, rd_addr_i, wr_req_i, wr_addr_i} = {rd, ra, wr, wa};
      {wr_data_i, wr_lane_en_n_i} = {wd, wen};
      if (wr) begin
        m = mem[wa];
        for (int s = 0; s < 4; s++)
          if (!wen[s]) m[s*9 +: 9] = wd[s*9 +: 9];
        mem[wa] = m;
        if (wen[0] != wen[2] || wen[1] != wen[3]) ecc_exp = 1'b0;
      end
      if (rd) exp_q.push_back(mem[ra]);
      @(posedge clk_i);
      #1;
      {rd_req_i, wr_req_i} = 2'h0;
    end
  endtask

  task automatic drain();
    cyc = 0;
    while (exp_q.size() > 0 && cyc < 60) begin
      @(posedge clk_i);
      cyc++;
    end
    check(exp_q.size(), 36'h0);
    #1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {term_en_i, rd_req_i, wr_req_i, rst_n_i} = 4'h0;
    {rd_addr_i, wr_addr_i, wr_data_i, wr_lane_en_n_i} = '0;
    mismatches = 0;
    check_count = 0;
    do_reset();
    // Back-to-back full writes, each slot after the first reading the previous address
    for (int i = 0; i < 6; i++)
      op(i > 0, ADDR_W'(i * 204 - 201), 1'b1, ADDR_W'(i * 204 + 3),
        36'h9a5c3e1f7 + 36'(i) * 36'h10203, 4'h0);
    op(1'b1, 10'h3ff, 1'b0, 10'h000, 36'h0, 4'h0);
    // Same-slot read and write, then a write deselect storing nothing
    op(1'b1, 10'h003, 1'b1, 10'h003, 36'h0f0f0f0f0, 4'h0);
    op(1'b1, 10'h003, 1'b0, 10'h0cf, 36'hfffffffff, 4'h0);
    op(1'b1, 10'h0cf, 1'b0, 10'h000, 36'h0, 4'h0);
    // Lane masks alike on both beats, abort included
    for (int j = 0; j < 4; j++) begin
      op(1'b0, 10'h0, 1'b1, 10'h003, 36'h123456789 ^ 36'(j), MASKS[j*4 +: 4]);
      op(1'b1, 10'h003, 1'b0, 10'h0, 36'h0, 4'h0);
    end
    check(ecc_on_o, ecc_exp);
    // Idle drive with termination on, then off
    term_en_i = 1'b1;
    op(1'b1, 10'h19b, 1'b0, 10'h0, 36'h0, 4'h0);
    op(1'b0, 10'h0, 1'b0, 10'h0, 36'h0, 4'h0);
    op(1'b0, 10'h0, 1'b0, 10'h0, 36'h0, 4'h0);
    term_en_i = 1'b0;
    // Half writes on each beat switch correction off until reset
    op(1'b0, 10'h0, 1'b1, 10'h267, 36'h5a5a5a5a5, 4'h4);
    op(1'b1, 10'h267, 1'b1, 10'h333, 36'h3c3c3c3c3, 4'h2);
    op(1'b1, 10'h333, 1'b0, 10'h0, 36'h0, 4'h0);
    check(ecc_on_o, 1'b0);
    op(1'b0, 10'h0, 1'b1, 10'h267, 36'h0, 4'h0);
    check(ecc_on_o, 1'b0);
    drain();
    // Mid-run reset restores correction
    do_reset();
    op(1'b0, 10'h0, 1'b1, 10'h011, 36'h2468ace13, 4'h0);
    op(1'b1, 10'h011, 1'b0, 10'h0, 36'h0, 4'h0);
    drain();
    check(ecc_on_o, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
